/* dv/gpc_monitor.sv */
// Port assertions for the GPIO pin control block
`timescale 1ns/1ps
module gpc_monitor
   import gpc_pkg::*;
(
   input wire logic                pclk,    // Clock
   input wire logic                presetn, // Reset, low
   input wire logic                psel,    // Select
   input wire logic                penable, // Enable
   input wire logic                pwrite,  // Direction
   input wire logic [ADDR_W-1:0]   paddr,   // Address
   input wire logic [DATA_W-1:0]   prdata,  // Read data
   input wire logic                pready,  // Ready
   input wire logic                pslverr, // Error
   input wire logic [NUM_PINS-1:0] pin_out, // Pad levels
   input wire logic [NUM_PINS-1:0] pin_oe,  // Pad enables
   input wire logic                irq      // Interrupt
);
   logic [9:0] idx;
   logic       wr_done;
   assign idx = paddr[11:2];
   assign wr_done = psel && penable && pwrite && pready;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   rdy_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   rdy_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready held");
   rdy_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   err_with_rdy_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready |-> prdata == '0)
      else $error("read data outside access");
   unmapped_err_a: assert property (psel && !penable &&
      !(idx inside {[10'h035:10'h03C], [10'h041:10'h044]}) |=> pslverr)
      else $error("no error on unmapped");
   rsvd_zero_a: assert property (
      psel && !penable && !pwrite && idx inside {[10'h035:10'h03C]} |=>
      (prdata & (($past(idx) == IDX_DENS1) ? 32'hFFFFFF70 : 32'hFFFFFF78))
      == '0) else $error("reserved bits read nonzero");
   undriven_low_a: assert property ((pin_out & ~pin_oe) == '0)
      else $error("level on undriven pin");
   irq_clear_a: assert property (
      $fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("irq dropped without write");
   cover property (wr_done && pslverr);
   cover property ($rose(irq));
   cover property (pready && !pwrite && !pslverr);
endmodule : gpc_monitor

bind gpc_pin_ctrl gpc_monitor u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

/* dv/gpc_pin_ctrl_tb.sv */
// Self-checking bench for the GPIO pin control block
`timescale 1ns/1ps
module gpc_pin_ctrl_tb
   import gpc_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn, mpr, psel, penable, pwrite, pready, pslverr;
   logic        err, irq, irrx;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  pin_in, pin_out, pin_oe, alt;
   int          mismatches, num_checks;

   always #2 pclk = ~pclk;

   gpc_pin_ctrl uut (.pclk(pclk), .presetn(presetn),
      .main_power_reset(mpr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .fan_speed_out_b(alt[0]), .fan_speed_out_a(alt[1]),
      .infrared_transmit_b(alt[3]), .keyboard_ctrl_reset_out(alt[4]),
      .gate_a20_out(alt[5]), .drive_density_sel0(alt[6]),
      .drive_density_sel1(alt[7]), .infrared_receive_b(irrx), .irq(irq));

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wt(int c);
      repeat (c) @(posedge pclk);
   endtask : wt

   // One APB transfer; waits for ready under a bound
   task automatic apb(logic wr, logic [9:0] idx, logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk("pready", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic t_rst;
      logic [7:0] dflt [8];
      dflt = '{8'h01, 8'h01, 8'h05, 8'h04, 8'h01, 8'h01, 8'h01, 8'h01};
      wt(3);
      chk("oe_rst", pin_oe, 8'h08);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, IDX_FAN_B + 10'(i), 8'h00);
         chk("rst", rd, 32'(dflt[i]));
      end
   endtask : t_rst

   task automatic t_rw;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, IDX_FAN_B + 10'(i), 8'hFF);
         apb(1'b0, IDX_FAN_B + 10'(i), 8'h00);
         chk("rsvd", rd, (i == 7) ? 32'h8F : 32'h87);
      end
      apb(1'b1, 10'h03D, 8'h5A);
      chk("err_wr", err, 1'b1);
      apb(1'b0, 10'h03D, 8'h00);
      chk("err_rd", err, 1'b1);
      chk("err_data", rd, 32'h0);
   endtask : t_rw

   task automatic t_out;
      apb(1'b1, IDX_OUT_DATA, 8'h01);
      apb(1'b1, IDX_FAN_B, 8'h00);
      wt(2);
      chk("pp", {pin_oe[0], pin_out[0]}, 2'h3);
      apb(1'b1, IDX_FAN_B, 8'h02);
      wt(2);
      chk("inv", {pin_oe[0], pin_out[0]}, 2'h2);
      apb(1'b1, IDX_FAN_B, 8'h80);
      wt(2);
      chk("od1", pin_oe[0], 1'b0);
      apb(1'b1, IDX_OUT_DATA, 8'h00);
      wt(2);
      chk("od0", {pin_oe[0], pin_out[0]}, 2'h2);
      for (int i = 0; i < 8; i++) begin
         if (i == 2) continue;
         apb(1'b1, IDX_FAN_B + 10'(i), 8'h04);
         alt <= 8'h01 << i;
         wt(2);
         chk("alt", pin_out & pin_oe, alt);
         alt <= 8'h00;
      end
   endtask : t_out

   task automatic t_in;
      apb(1'b1, IDX_IR_RX_B, 8'h05);
      pin_in <= 8'h04;
      wt(5);
      chk("irrx", irrx, 1'b1);
      apb(1'b0, IDX_PIN_LVL, 8'h00);
      chk("lvl", rd[2], 1'b1);
      apb(1'b1, IDX_IR_RX_B, 8'h07);
      wt(5);
      chk("irrx_inv", irrx, 1'b0);
      apb(1'b0, IDX_PIN_LVL, 8'h00);
      chk("lvl_inv", rd[2], 1'b0);
   endtask : t_in

   task automatic t_irq;
      apb(1'b1, IDX_IRQ_MASK, 8'h01);
      apb(1'b1, IDX_DENS1, 8'h09);
      apb(1'b1, IDX_IRQ_STAT, 8'h01);
      wt(2);
      chk("irq_idle", irq, 1'b0);
      chk("irq_oe", pin_oe[7], 1'b0);
      // Rising then falling edge
      for (int k = 0; k < 2; k++) begin
         pin_in <= pin_in ^ 8'h80;
         wt(6);
         chk("irq_edge", irq, 1'b1);
         apb(1'b1, IDX_IRQ_STAT, 8'h01);
         wt(2);
         chk("irq_clr", irq, 1'b0);
      end
      apb(1'b1, IDX_IRQ_MASK, 8'h00);
      pin_in <= pin_in ^ 8'h80;
      wt(6);
      chk("irq_mask", irq, 1'b0);
      apb(1'b0, IDX_IRQ_STAT, 8'h00);
      chk("stat", rd, 32'h1);
   endtask : t_irq

   task automatic t_main;
      apb(1'b1, IDX_FAN_A, 8'h83);
      apb(1'b1, IDX_IR_TX_B, 8'h83);
      mpr <= 1'b1;
      wt(6);
      mpr <= 1'b0;
      wt(4);
      apb(1'b0, IDX_FAN_B, 8'h00);
      chk("main_b", rd, 32'h0);
      apb(1'b0, IDX_FAN_A, 8'h00);
      chk("main_a", rd, 32'h0);
      apb(1'b0, IDX_IR_TX_B, 8'h00);
      chk("main_tx", rd, 32'h04);
      apb(1'b0, IDX_IR_RX_B, 8'h00);
      chk("main_rx", rd, 32'h07);
   endtask : t_main

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   initial begin
      #200000;
      mismatches++;
      end_sim();
   end

   initial begin
      presetn = 1'b0;
      mpr = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pin_in = '0;
      alt = '0;
      mismatches = 0;
      num_checks = 0;
      wt(20);
      presetn <= 1'b1;
      t_rst();
      t_rw();
      t_out();
      t_in();
      t_irq();
      t_main();
      presetn <= 1'b0;
      wt(2);
      presetn <= 1'b1;
      t_rst();
      end_sim();
   end
endmodule : gpc_pin_ctrl_tb

/* rtl/gpc_pin_ctrl.sv */
// GPIO pin control registers, pin muxing and edge interrupt
`timescale 1ns/1ps

// Function
// RQ1: Bit 0 set means input, clear output
// RQ2: Bit 1 set inverts pin signal
// RQ3: Bit 7 set open-drain, clear push-pull
// RQ4: Bit 2 selects alternate function; 6:3 reserved
// RQ5: Offset 35 fan B; 01 standby, 00 main
// RQ6: Offset 36 fan A; 01 standby, 00 main
// RQ7: Offset 37 infrared receive B; resets 05
// RQ8: Offset 38 infrared transmit B; resets 04
// RQ9: Offset 39 keyboard reset; standby default 01
// RQ10: Offset 3A gate A20; standby default 01
// RQ11: Offset 3B density select 0; default 01
// RQ12: Offset 3C two-bit select in bits 3:2
// RQ13: Select 10 gives either-edge interrupt input 2
// RQ14: Reserved bits read zero; others read back
// RQ15: Inversion applies to input and output
module gpc_pin_ctrl
   import gpc_pkg::*;
(
   input  wire logic                pclk,               // APB clock
   input  wire logic                presetn,            // Standby POR, low
   input  wire logic                main_power_reset,   // Main POR/hard rst
   input  wire logic                psel,               // APB select
   input  wire logic                penable,            // APB enable
   input  wire logic                pwrite,             // APB direction
   input  wire logic [ADDR_W-1:0]   paddr,              // APB byte address
   input  wire logic [DATA_W-1:0]   pwdata,             // APB write data
   input  wire logic [3:0]          pstrb,              // APB byte strobes
   output logic      [DATA_W-1:0]   prdata,             // APB read data
   output logic                     pready,             // APB ready
   output logic                     pslverr,            // APB error
   input  wire logic [NUM_PINS-1:0] pin_in,             // Pad input levels
   output logic      [NUM_PINS-1:0] pin_out,            // Pad output levels
   output logic      [NUM_PINS-1:0] pin_oe,             // Pad drive enables
   input  wire logic                fan_speed_out_b,    // Fan B source
   input  wire logic                fan_speed_out_a,    // Fan A source
   input  wire logic                infrared_transmit_b,// IR TX B source
   input  wire logic                keyboard_ctrl_reset_out, // Kbd reset src
   input  wire logic                gate_a20_out,       // Gate A20 source
   input  wire logic                drive_density_sel0, // Density 0 source
   input  wire logic                drive_density_sel1, // Density 1 source
   output logic                     infrared_receive_b, // IR RX B to port
   output logic                     irq                 // Interrupt level
);

   logic [7:0]          ctrl_ff [NUM_PINS];
   logic [7:0]          out_data_ff;
   logic [7:0]          irq_stat_ff;
   logic [7:0]          irq_mask_ff;
   logic [NUM_PINS-1:0] pin_meta_ff;
   logic [NUM_PINS-1:0] pin_sync_ff;
   logic [1:0]          mrst_sync_ff;
   logic                edge_prev_ff;
   logic                edge_armed_ff;
   logic [DATA_W-1:0]   prdata_ff;
   logic                pready_ff;
   logic                pslverr_ff;
   logic [NUM_PINS-1:0] pin_out_ff;
   logic [NUM_PINS-1:0] pin_oe_ff;
   logic                ir_rx_ff;
   logic                irq_ff;

   logic [NUM_PINS-1:0] alt_src;
   logic [NUM_PINS-1:0] alt_sel;
   logic [NUM_PINS-1:0] pin_level;
   logic [NUM_PINS-1:0] nxt_pin_out;
   logic [NUM_PINS-1:0] nxt_pin_oe;
   logic [9:0]          word_idx;
   logic                acc_write;
   logic                setup;
   logic                edge_mode;
   logic                edge_event;
   logic [7:0]          nxt_irq_stat;
   logic [7:0]          wr_byte;
   logic [DATA_W-1:0]   nxt_prdata;
   logic                nxt_pslverr;

   // Writable bits of a pin control register
   function automatic logic [7:0] ctrl_wmask(input int pin);
      if (pin == PIN_DENS1) begin
         return WMASK_DUAL;                                      // RQ12
      end else begin
         return WMASK_SINGLE;                                    // RQ4
      end
   endfunction : ctrl_wmask

   // Pin number for a word index, NUM_PINS when not a pin register
   function automatic int pin_of(input logic [9:0] idx);
      if (idx >= IDX_FAN_B && idx <= IDX_DENS1) begin
         return int'(idx - IDX_FAN_B);
      end else begin
         return NUM_PINS;
      end
   endfunction : pin_of

   assign word_idx  = paddr[11:2];
   assign setup     = psel && !penable && !pready_ff;
   assign acc_write = psel && penable && pready_ff && pwrite;
   assign wr_byte   = pstrb[0] ? pwdata[7:0] : 8'h00;

   // Alternate function sources by pin
   always_comb begin
      alt_src    = '0;
      alt_src[0] = fan_speed_out_b;                              // RQ5
      alt_src[1] = fan_speed_out_a;                              // RQ6
      alt_src[3] = infrared_transmit_b;                          // RQ8
      alt_src[4] = keyboard_ctrl_reset_out;                      // RQ9
      alt_src[5] = gate_a20_out;                                 // RQ10
      alt_src[6] = drive_density_sel0;                           // RQ11
      alt_src[7] = drive_density_sel1;                           // RQ12
   end

   // Alternate select per pin
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         alt_sel[i] = ctrl_ff[i][BIT_ALT];                       // RQ4
      end
      alt_sel[PIN_DENS1] =
         (ctrl_ff[PIN_DENS1][BIT_ALT_HI:BIT_ALT] == SEL2_DENS1); // RQ12
   end

   assign edge_mode =
      (ctrl_ff[PIN_DENS1][BIT_ALT_HI:BIT_ALT] == SEL2_IRQ);      // RQ13

   // Pad drive: output mode only, inversion then driver type
   always_comb begin
      logic v;
      v = 1'b0;
      for (int i = 0; i < NUM_PINS; i++) begin
         v = (alt_sel[i] ? alt_src[i] : out_data_ff[i])
             ^ ctrl_ff[i][BIT_POL];                              // RQ2 RQ15
         if (ctrl_ff[i][BIT_DIR] || (i == PIN_DENS1 && edge_mode)) begin
            nxt_pin_out[i] = 1'b0;                               // RQ1
            nxt_pin_oe[i]  = 1'b0;
         end else if (ctrl_ff[i][BIT_OD]) begin
            nxt_pin_out[i] = 1'b0;                               // RQ3
            nxt_pin_oe[i]  = !v;
         end else begin
            nxt_pin_out[i] = v;                                  // RQ3
            nxt_pin_oe[i]  = 1'b1;
         end
      end
   end

   // Input level after polarity
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_level[i] = pin_sync_ff[i] ^ ctrl_ff[i][BIT_POL];    // RQ15
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
      end else begin
         pin_meta_ff <= pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mrst_sync_ff <= '0;
      end else begin
         mrst_sync_ff <= {mrst_sync_ff[0], main_power_reset};
      end
   end

   // Pin control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            ctrl_ff[i] <= RST_STBY[i];                   // RQ5 RQ6 RQ7 RQ8
         end
      end else if (mrst_sync_ff[1]) begin
         ctrl_ff[0] <= RST_MAIN_FAN;                             // RQ5
         ctrl_ff[1] <= RST_MAIN_FAN;                             // RQ6
         ctrl_ff[3] <= RST_MAIN_IRT;                             // RQ8
      end else if (acc_write && pin_of(word_idx) < NUM_PINS) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (i == pin_of(word_idx)) begin
               ctrl_ff[i] <= wr_byte & ctrl_wmask(i);            // RQ14
            end
         end
      end
   end

   // Output data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_data_ff <= RST_OUT_DATA;
      end else if (acc_write && word_idx == IDX_OUT_DATA) begin
         out_data_ff <= wr_byte;
      end
   end

   // Interrupt mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= RST_IRQ_MASK;
      end else if (acc_write && word_idx == IDX_IRQ_MASK) begin
         irq_mask_ff <= wr_byte & IRQ_WMASK;
      end
   end

   // Previous level of the interrupt pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_prev_ff <= 1'b0;
      end else begin
         edge_prev_ff <= pin_level[PIN_DENS1];
      end
   end

   // Armed one cycle after mode entry, no false edge on entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_armed_ff <= 1'b0;
      end else begin
         edge_armed_ff <= edge_mode;
      end
   end

   assign edge_event = edge_mode && edge_armed_ff
                       && (pin_level[PIN_DENS1] != edge_prev_ff); // RQ13

   // Sticky status: set wins over write-one-to-clear
   always_comb begin
      nxt_irq_stat = irq_stat_ff;
      if (acc_write && word_idx == IDX_IRQ_STAT) begin
         nxt_irq_stat = irq_stat_ff & ~wr_byte;
      end
      if (edge_event) begin
         nxt_irq_stat[IRQ_EDGE_BIT] = 1'b1;                      // RQ13
      end
      nxt_irq_stat = nxt_irq_stat & IRQ_WMASK;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // Interrupt level follows the next status under the mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   // Read decode
   always_comb begin
      nxt_prdata  = '0;
      nxt_pslverr = 1'b0;
      if (pin_of(word_idx) < NUM_PINS) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (i == pin_of(word_idx)) begin
               nxt_prdata[7:0] = ctrl_ff[i];                     // RQ14
            end
         end
      end else if (word_idx == IDX_OUT_DATA) begin
         nxt_prdata[7:0] = out_data_ff;
      end else if (word_idx == IDX_PIN_LVL) begin
         nxt_prdata[7:0] = pin_level;
      end else if (word_idx == IDX_IRQ_STAT) begin
         nxt_prdata[7:0] = irq_stat_ff;
      end else if (word_idx == IDX_IRQ_MASK) begin
         nxt_prdata[7:0] = irq_mask_ff;
      end else begin
         nxt_pslverr = 1'b1;
      end
   end

   // APB answer: one access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
      end
   end

   // Error flag, only together with ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= setup && nxt_pslverr;
      end
   end

   // Read data, zero outside a read access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else begin
         if (setup && !pwrite) begin
            prdata_ff <= nxt_prdata;
         end else if (!setup) begin
            prdata_ff <= '0;
         end
      end
   end

   // Pad output levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_ff <= '0;
      end else begin
         pin_out_ff <= nxt_pin_out;
      end
   end

   // Pad drive enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_oe_ff <= '0;
      end else begin
         pin_oe_ff <= nxt_pin_oe;
      end
   end

   // Infrared receive B, only when pin 2 is an alternate input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_rx_ff <= 1'b0;
      end else begin
         ir_rx_ff <= alt_sel[2] && ctrl_ff[2][BIT_DIR]
                     && pin_level[2];                            // RQ7
      end
   end

   assign prdata             = prdata_ff;
   assign pready             = pready_ff;
   assign pslverr            = pslverr_ff;
   assign pin_out            = pin_out_ff;
   assign pin_oe             = pin_oe_ff;
   assign infrared_receive_b = ir_rx_ff;
   assign irq                = irq_ff;

endmodule : gpc_pin_ctrl

/* rtl/gpc_pkg.sv */
// Package for the group three and four GPIO pin control block
package gpc_pkg;
   localparam int          NUM_PINS     = 8;
   localparam int          ADDR_W       = 12;
   localparam int          DATA_W       = 32;
   localparam int          REG_W        = 8;
   // Register indices; byte address is four times the index
   localparam logic [9:0]  IDX_FAN_B    = 10'h035;
   localparam logic [9:0]  IDX_FAN_A    = 10'h036;
   localparam logic [9:0]  IDX_IR_RX_B  = 10'h037;
   localparam logic [9:0]  IDX_IR_TX_B  = 10'h038;
   localparam logic [9:0]  IDX_KBD_RST  = 10'h039;
   localparam logic [9:0]  IDX_GATE_A20 = 10'h03A;
   localparam logic [9:0]  IDX_DENS0    = 10'h03B;
   localparam logic [9:0]  IDX_DENS1    = 10'h03C;
   localparam logic [9:0]  IDX_OUT_DATA = 10'h041;
   localparam logic [9:0]  IDX_PIN_LVL  = 10'h042;
   localparam logic [9:0]  IDX_IRQ_STAT = 10'h043;
   localparam logic [9:0]  IDX_IRQ_MASK = 10'h044;
   // Control field positions
   localparam int          BIT_DIR      = 0;
   localparam int          BIT_POL      = 1;
   localparam int          BIT_ALT      = 2;
   localparam int          BIT_ALT_HI   = 3;
   localparam int          BIT_OD       = 7;
   localparam int          IRQ_EDGE_BIT = 0;
   localparam int          PIN_DENS1    = 7;
   // Writable bit masks
   localparam logic [7:0]  WMASK_SINGLE = 8'h87;
   localparam logic [7:0]  WMASK_DUAL   = 8'h8F;
   localparam logic [7:0]  IRQ_WMASK    = 8'h01;
   // Two-bit select encodings for the last pin
   localparam logic [1:0]  SEL2_GPIO    = 2'h0;
   localparam logic [1:0]  SEL2_DENS1   = 2'h1;
   localparam logic [1:0]  SEL2_IRQ     = 2'h2;
   // Standby-power defaults, pin 0 first
   localparam logic [7:0]  RST_STBY [NUM_PINS] = '{
      8'h01, 8'h01, 8'h05, 8'h04, 8'h01, 8'h01, 8'h01, 8'h01};
   // Main-power and hard reset defaults; out data and mask defaults load on standby reset only
   localparam logic [7:0]  RST_MAIN_FAN = 8'h00;
   localparam logic [7:0]  RST_MAIN_IRT = 8'h04;
   localparam logic [7:0]  RST_OUT_DATA = 8'h00;
   localparam logic [7:0]  RST_IRQ_MASK = 8'h00;
endpackage : gpc_pkg
